// ### core/i2srp_pkg.sv
`default_nettype none

package i2srp_pkg;

    // Fixed upper bits of the seven-bit bus address
    localparam logic [4:0]  ADDR_FIXED    = 5'h13;
    // Byte and index widths
    localparam int          BYTE_W        = 8;
    localparam int          IDX_W         = 7;
    localparam int          PAGE_W        = 8;
    localparam int          MEM_AW        = IDX_W + PAGE_W;
    localparam int          MEM_DEPTH     = 32768;
    // Index byte layout
    localparam int          AUTO_INC_BIT  = 7;
    // Index values
    localparam logic [6:0]  IDX_PAGE_SEL  = 7'h00;
    localparam logic [6:0]  IDX_TOP       = 7'h7f;
    localparam logic [6:0]  IDX_FIRST     = 7'h00;
    localparam logic [6:0]  IDX_ONE       = 7'h01;
    // Bit counter values
    localparam logic [3:0]  CNT_ZERO      = 4'h0;
    localparam logic [3:0]  CNT_ONE       = 4'h1;
    localparam logic [3:0]  CNT_RX_BYTE   = 4'h8;
    localparam logic [3:0]  CNT_TX_LAST   = 4'h7;
    // Reset values
    localparam logic [7:0]  PAGE_RST      = 8'h00;
    localparam logic [7:0]  BYTE_RST      = 8'h00;
    localparam logic [14:0] WADDR_RST     = 15'h0000;

    // Bus engine states
    typedef enum logic [2:0] {
        I2SRP_IDLE,
        I2SRP_RX,
        I2SRP_RX_ACK,
        I2SRP_TX,
        I2SRP_TX_ACK
    } i2srp_state_t;

    // Meaning of the byte being received
    typedef enum logic [1:0] {
        I2SRP_K_ADDR,
        I2SRP_K_INDEX,
        I2SRP_K_DATA
    } i2srp_kind_t;

    // Index step with wrap at the top of the page
    function automatic logic [6:0] i2srp_idx_step(input logic [6:0] idx, input logic en);
        if (!en) begin
            return idx;
        end
        if (idx == IDX_TOP) begin
            return IDX_FIRST;
        end
        return idx + IDX_ONE;
    endfunction

endpackage

`default_nettype wire

// ### core/i2srp_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for pins from outside the clock domain
module i2srp_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0    // Idle level of each pin, held in reset
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;    // First stage, read only by the second

    ////////////////////////////////////////////////////////////////////////////////
    // Two flops in series
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

`default_nettype wire

// ### core/i2srp_slave_port.sv
// Behaviour
// - Target only, standard and fast speeds
// - Address upper five bits are 10011
// - Low address bits from select pins
// - Address bytes 0x98 to 0x9E, hi pin bit2
// - Acknowledge only own address, ignore others
// - Master makes start, stop, direction
// - Start, address, ack, then stop frames
// - Write: index byte then data, all acked
// - Store byte then advance index by one if auto-increment set
// - Index wraps from 0x7F to zero
// - Read sends indexed byte, then advances if auto-increment set
// - Repeated start accepted mid transaction
// - Auto-increment covers consecutive locations
// - Index zero selects page 0 to 255
`timescale 1ns/1ps
`default_nettype none

module i2srp_slave_port (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output var  logic        sda_out,
    output var  logic        sda_oe_n,
    input  wire logic        addr_select_hi_pin,
    input  wire logic        addr_select_lo_pin,
    output var  logic [7:0]  page_sel,
    output var  logic        reg_wr_strobe,
    output var  logic [14:0] reg_wr_addr,
    output var  logic [7:0]  reg_wr_data
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and bus event detection

    logic [3:0] pins_s;      // Synchronised pins
    logic       scl_s;       // Clock line, synchronised
    logic       sda_s;       // Data line, synchronised
    logic       hi_s;        // High select pin, synchronised
    logic       lo_s;        // Low select pin, synchronised
    logic       scl_q;       // Clock line, one cycle older
    logic       sda_q;       // Data line, one cycle older

    i2srp_sync #(
        .WIDTH   (4),
        .RST_VAL (4'hc)    // Bus lines idle high, so no false edge follows reset
    ) u_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in ({scl_in, sda_in, addr_select_hi_pin, addr_select_lo_pin}),
        .sync_out (pins_s)
    );

    assign scl_s = pins_s[3];
    assign sda_s = pins_s[2];
    assign hi_s  = pins_s[1];
    assign lo_s  = pins_s[0];

    // Delay stage for edge finding
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_q <= 1'b1;    // Matches the idle level of the bus lines
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    logic       scl_rise;    // Clock line rising
    logic       scl_fall;    // Clock line falling
    logic       start_ev;    // Start or repeated start seen
    logic       stop_ev;     // Stop seen
    logic [6:0] own_addr;    // Configured bus address

    // Sampling at the core rate resolves both bus speeds
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_ev  = scl_s & scl_q & ~sda_q & sda_s;
    assign own_addr = {i2srp_pkg::ADDR_FIXED, hi_s, lo_s};

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [7:0]  mem [0:i2srp_pkg::MEM_DEPTH-1];   // All pages, index zero unused
    logic        mem_we;                           // Store strobe
    logic [14:0] mem_waddr;                        // Store location
    logic [7:0]  mem_wdata;                        // Store value

    // Array write, no reset
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus engine

    i2srp_pkg::i2srp_state_t state, next_state;    // Engine state
    i2srp_pkg::i2srp_kind_t  kind, next_kind;      // Byte being received
    logic [3:0]  cnt, next_cnt;                    // Bit counter
    logic [7:0]  shift, next_shift;                // Receive shifter
    logic [7:0]  tx, next_tx;                      // Transmit shifter
    logic        rw, next_rw;                      // Direction bit
    logic        auto_inc, next_auto_inc;          // Auto-increment flag
    logic [6:0]  index, next_index;                // Register index
    logic        more, next_more;                  // Master asked for more
    logic        next_oe_n;                        // Next data line enable
    logic [7:0]  next_page;                        // Next page select
    logic        next_wr_strobe;                   // Next write pulse
    logic [14:0] next_wr_addr;                     // Next write location
    logic [7:0]  next_wr_data;                     // Next write value
    logic        byte_done;                        // Eighth bit taken, clock low
    logic [7:0]  rd_byte;                          // Byte at the current index

    assign byte_done = (state == i2srp_pkg::I2SRP_RX) && scl_fall && (cnt == i2srp_pkg::CNT_RX_BYTE);
    // Index zero reads back the page select
    assign rd_byte   = (index == i2srp_pkg::IDX_PAGE_SEL) ? page_sel : mem[{page_sel, index}];

    // Next-state logic
    always_comb begin
        next_state     = state;
        next_kind      = kind;
        next_cnt       = cnt;
        next_shift     = shift;
        next_tx        = tx;
        next_rw        = rw;
        next_auto_inc  = auto_inc;
        next_index     = index;
        next_more      = more;
        next_oe_n      = sda_oe_n;
        next_page      = page_sel;
        next_wr_strobe = 1'b0;
        next_wr_addr   = reg_wr_addr;
        next_wr_data   = reg_wr_data;
        mem_we         = 1'b0;
        mem_waddr      = {page_sel, index};
        mem_wdata      = shift;
        if (stop_ev) begin
            // Stop ends the transaction and frees the line
            next_state = i2srp_pkg::I2SRP_IDLE;
            next_oe_n  = 1'b1;
        end else if (start_ev) begin
            // Start or repeated start begins a new address byte
            next_state = i2srp_pkg::I2SRP_RX;
            next_kind  = i2srp_pkg::I2SRP_K_ADDR;
            next_cnt   = i2srp_pkg::CNT_ZERO;
            next_oe_n  = 1'b1;
        end else begin
            case (state)
                i2srp_pkg::I2SRP_IDLE: begin
                    // Waiting for a start
                    next_oe_n = 1'b1;
                end
                i2srp_pkg::I2SRP_RX: begin
                    if (scl_rise && (cnt != i2srp_pkg::CNT_RX_BYTE)) begin
                        // Sample a bit, most significant first
                        next_shift = {shift[6:0], sda_s};
                        next_cnt   = cnt + i2srp_pkg::CNT_ONE;
                    end else if (byte_done) begin
                        next_state = i2srp_pkg::I2SRP_RX_ACK;
                        next_oe_n  = 1'b0;
                        case (kind)
                            i2srp_pkg::I2SRP_K_ADDR: begin
                                if (shift[7:1] == own_addr) begin
                                    next_rw = shift[0];
                                end else begin
                                    // Foreign address, stay off the bus
                                    next_state = i2srp_pkg::I2SRP_IDLE;
                                    next_oe_n  = 1'b1;
                                end
                            end
                            i2srp_pkg::I2SRP_K_INDEX: begin
                                next_auto_inc = shift[i2srp_pkg::AUTO_INC_BIT];
                                next_index    = shift[6:0];
                            end
                            default: begin
                                // Data byte: index zero is the page select
                                if (index == i2srp_pkg::IDX_PAGE_SEL) begin
                                    next_page = shift;
                                end else begin
                                    mem_we = 1'b1;
                                end
                                next_wr_strobe = 1'b1;
                                next_wr_addr   = {page_sel, index};
                                next_wr_data   = shift;
                                next_index     = i2srp_pkg::i2srp_idx_step(index, auto_inc);
                            end
                        endcase
                    end
                end
                i2srp_pkg::I2SRP_RX_ACK: begin
                    if (scl_fall) begin
                        // Acknowledge ends, turn to the next byte
                        next_oe_n = 1'b1;
                        next_cnt  = i2srp_pkg::CNT_ZERO;
                        if ((kind == i2srp_pkg::I2SRP_K_ADDR) && rw) begin
                            next_state = i2srp_pkg::I2SRP_TX;
                            next_tx    = rd_byte;
                            next_oe_n  = rd_byte[7];
                            next_index = i2srp_pkg::i2srp_idx_step(index, auto_inc);
                        end else begin
                            next_state = i2srp_pkg::I2SRP_RX;
                            next_kind  = (kind == i2srp_pkg::I2SRP_K_ADDR) ? i2srp_pkg::I2SRP_K_INDEX
                                                                           : i2srp_pkg::I2SRP_K_DATA;
                        end
                    end
                end
                i2srp_pkg::I2SRP_TX: begin
                    if (scl_fall) begin
                        if (cnt == i2srp_pkg::CNT_TX_LAST) begin
                            // Last bit sent, let the master answer
                            next_state = i2srp_pkg::I2SRP_TX_ACK;
                            next_oe_n  = 1'b1;
                        end else begin
                            next_tx   = {tx[6:0], 1'b0};
                            next_oe_n = tx[6];
                            next_cnt  = cnt + i2srp_pkg::CNT_ONE;
                        end
                    end
                end
                i2srp_pkg::I2SRP_TX_ACK: begin
                    if (scl_rise) begin
                        next_more = ~sda_s;
                    end else if (scl_fall) begin
                        next_cnt = i2srp_pkg::CNT_ZERO;
                        if (more) begin
                            next_state = i2srp_pkg::I2SRP_TX;
                            next_tx    = rd_byte;
                            next_oe_n  = rd_byte[7];
                            next_index = i2srp_pkg::i2srp_idx_step(index, auto_inc);
                        end else begin
                            // Not acknowledged: wait for stop
                            next_state = i2srp_pkg::I2SRP_IDLE;
                            next_oe_n  = 1'b1;
                        end
                    end
                end
                default: begin
                    next_state = i2srp_pkg::I2SRP_IDLE;
                    next_oe_n  = 1'b1;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state         <= i2srp_pkg::I2SRP_IDLE;
            kind          <= i2srp_pkg::I2SRP_K_ADDR;
            cnt           <= i2srp_pkg::CNT_ZERO;
            shift         <= i2srp_pkg::BYTE_RST;
            tx            <= i2srp_pkg::BYTE_RST;
            rw            <= 1'b0;
            auto_inc      <= 1'b0;
            index         <= i2srp_pkg::IDX_FIRST;
            more          <= 1'b0;
            sda_oe_n      <= 1'b1;
            sda_out       <= 1'b0;
            page_sel      <= i2srp_pkg::PAGE_RST;
            reg_wr_strobe <= 1'b0;
            reg_wr_addr   <= i2srp_pkg::WADDR_RST;
            reg_wr_data   <= i2srp_pkg::BYTE_RST;
        end else begin
            state         <= next_state;
            kind          <= next_kind;
            cnt           <= next_cnt;
            shift         <= next_shift;
            tx            <= next_tx;
            rw            <= next_rw;
            auto_inc      <= next_auto_inc;
            index         <= next_index;
            more          <= next_more;
            sda_oe_n      <= next_oe_n;
            sda_out       <= 1'b0;   // Line is only ever pulled low
            page_sel      <= next_page;
            reg_wr_strobe <= next_wr_strobe;
            reg_wr_addr   <= next_wr_addr;
            reg_wr_data   <= next_wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_addr_done;
        byte_done && (kind == i2srp_pkg::I2SRP_K_ADDR);
    endsequence

    sequence s_data_done;
        byte_done && (kind == i2srp_pkg::I2SRP_K_DATA);
    endsequence

    property p_drive_clock_low;
        $fell(sda_oe_n) |-> !scl_s;
    endproperty
    a_drive_clock_low: assert property (p_drive_clock_low) else $error("Data line pulled with clock high");

    property p_addr_ignore;
        s_addr_done ##0 (shift[7:1] != own_addr) |=> (state == i2srp_pkg::I2SRP_IDLE) && sda_oe_n;
    endproperty
    a_addr_ignore: assert property (p_addr_ignore) else $error("Foreign address not ignored");

    property p_addr_ack;
        s_addr_done ##0 (shift[7:1] == {5'h13, hi_s, lo_s}) |=> !sda_oe_n [*2];
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("Own address not acknowledged");

    property p_data_ack;
        s_data_done |=> !sda_oe_n && (state == i2srp_pkg::I2SRP_RX_ACK);
    endproperty
    a_data_ack: assert property (p_data_ack) else $error("Data byte not acknowledged");

    property p_wrap;
        s_data_done ##0 auto_inc && (index == 7'h7f) |=> (index == 7'h00);
    endproperty
    a_wrap: assert property (p_wrap) else $error("Index did not wrap");

    property p_step;
        s_data_done ##0 auto_inc && (index != 7'h7f) |=> (index == $past(index) + 7'h01);
    endproperty
    a_step: assert property (p_step) else $error("Index did not advance by one");

    property p_hold;
        s_data_done ##0 !auto_inc |=> $stable(index);
    endproperty
    a_hold: assert property (p_hold) else $error("Index moved without auto-increment");

    property p_page;
        s_data_done ##0 (index == 7'h00) |=> (page_sel == $past(shift)) ##1 reg_wr_strobe == 1'b0;
    endproperty
    a_page: assert property (p_page) else $error("Page select not taken");

    property p_stop;
        stop_ev |=> (state == i2srp_pkg::I2SRP_IDLE) && sda_oe_n;
    endproperty
    a_stop: assert property (p_stop) else $error("Stop did not end transaction");

    property p_restart;
        start_ev |=> (state == i2srp_pkg::I2SRP_RX) && (kind == i2srp_pkg::I2SRP_K_ADDR) && (cnt == 4'h0);
    endproperty
    a_restart: assert property (p_restart) else $error("Start not accepted");

    property p_nack_end;
        (state == i2srp_pkg::I2SRP_TX_ACK) && scl_fall && !more && !start_ev |=>
            (state == i2srp_pkg::I2SRP_IDLE) && sda_oe_n;
    endproperty
    a_nack_end: assert property (p_nack_end) else $error("Transmit went on after not-acknowledge");

endmodule

`default_nettype wire

// ### test/i2srp_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// Bus master: drives the clock line and releases or pulls the data line
module i2srp_master_model (
    output var  logic scl,
    output var  logic sda_rel,
    input  wire logic sda
);
    localparam int Q = 80;  // Quarter of a 320 ns bit slot in ns

    // Both lines idle released
    initial begin
        scl     = 1'b1;
        sda_rel = 1'b1;
    end

    // Start or repeated start: data falls while clock is high
    task automatic start();
        #Q sda_rel = 1'b1;
        #Q scl = 1'b1;
        #Q sda_rel = 1'b0;
        #Q scl = 1'b0;
    endtask

    // Stop: data rises while clock is high
    task automatic stop();
        #Q sda_rel = 1'b0;
        #Q scl = 1'b1;
        #Q sda_rel = 1'b1;
        #Q;
    endtask

    // One bit slot: clock low for two quarters, high for two, sampled mid-high
    task automatic bit_slot(input logic v, output logic s);
        #Q sda_rel = v;
        #Q scl = 1'b1;
        #Q s = sda;
        #Q scl = 1'b0;
    endtask

    // Send a byte, most significant bit first, then sample the ack
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(b[i], s);
        end
        bit_slot(1'b1, s);
        ack = ~s;
    endtask

    // Receive a byte; ack if more follow, nack the last
    task automatic recv(input logic more, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, s);
            b[i] = s;
        end
        bit_slot(~more, s);
    endtask
endmodule

`default_nettype wire

// ### test/i2srp_slave_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module i2srp_slave_port_tb_top;
    logic        clk;           // Core clock
    logic        arst_n;        // Reset, active low
    logic        scl;           // Bus clock from master
    logic        sda_rel;       // Master data, 1 = released
    logic        sda;           // Resolved data wire with pull-up
    logic        sel_hi;        // Upper select pin
    logic        sel_lo;        // Lower select pin
    logic        sda_out;       // Device drive value
    logic        sda_oe_n;      // Device drive enable, low = pull
    logic [7:0]  page_sel;      // Device page
    logic        reg_wr_strobe; // Device write pulse
    logic [14:0] reg_wr_addr;   // Device write address
    logic [7:0]  reg_wr_data;   // Device write data
    int          err_total;     // Mismatch count
    int          tests_run;     // Comparison count
    logic [7:0]  mem [logic [14:0]]; // Model array
    logic [7:0]  pg;            // Model page
    logic [6:0]  idx;           // Model index
    logic [22:0] seen [$];      // Observed writes

    // Wire-and of both parties over the pull-up
    assign sda = sda_rel & (sda_oe_n | sda_out);

    i2srp_slave_port dut (
        .clk                (clk),
        .arst_n             (arst_n),
        .scl_in             (scl),
        .sda_in             (sda),
        .sda_out            (sda_out),
        .sda_oe_n           (sda_oe_n),
        .addr_select_hi_pin (sel_hi),
        .addr_select_lo_pin (sel_lo),
        .page_sel           (page_sel),
        .reg_wr_strobe      (reg_wr_strobe),
        .reg_wr_addr        (reg_wr_addr),
        .reg_wr_data        (reg_wr_data)
    );

    i2srp_master_model bus_master (
        .scl     (scl),
        .sda_rel (sda_rel),
        .sda     (sda)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock and write monitor
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(negedge clk) begin
        if (reg_wr_strobe === 1'b1) begin
            seen.push_back({reg_wr_addr, reg_wr_data});
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare and closing tasks
    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_vec(input string what, input logic [22:0] exp, input logic [22:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Transactions with the reference model alongside
    task automatic open_idx(input logic [7:0] ib);
        logic a;
        bus_master.start();
        bus_master.send({8'h98 | {5'h00, sel_hi, sel_lo, 1'b0}}, a);
        chk_bit("write address ack", 1'b1, a);
        bus_master.send(ib, a);
        chk_bit("index ack", 1'b1, a);
        idx = ib[6:0];
    endtask

    task automatic wr_txn(input logic [7:0] ib, input int n);
        logic        a;
        logic [7:0]  d;
        logic [22:0] exp [$];
        open_idx(ib);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom_range(0, 255));
            bus_master.send(d, a);
            chk_bit("data ack", 1'b1, a);
            exp.push_back({pg, idx, d});
            if (idx == 7'h00) pg = d;
            else mem[{pg, idx}] = d;
            if (ib[7]) idx = (idx == 7'h7f) ? 7'h00 : idx + 7'h01;
        end
        bus_master.stop();
        chk_vec("write count", 23'(exp.size()), 23'(seen.size()));
        while (exp.size() > 0 && seen.size() > 0) begin
            chk_vec("write record", exp.pop_front(), seen.pop_front());
        end
        seen.delete();
        chk_vec("page select", 23'(pg), 23'(page_sel));
        $display("test write index %h bytes %0d done", ib, n);
    endtask

    task automatic rd_txn(input logic [7:0] ib, input int n);
        logic       a;
        logic [7:0] d;
        open_idx(ib);
        bus_master.start();
        bus_master.send({8'h99 | {5'h00, sel_hi, sel_lo, 1'b0}}, a);
        chk_bit("read address ack", 1'b1, a);
        for (int k = 0; k < n; k++) begin
            bus_master.recv(k < n - 1, d);
            chk_vec("read byte", 23'((idx == 7'h00) ? pg : mem[{pg, idx}]), 23'(d));
            if (ib[7]) idx = (idx == 7'h7f) ? 7'h00 : idx + 7'h01;
        end
        bus_master.stop();
        $display("test read index %h bytes %0d done", ib, n);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic a;
        arst_n    = 1'b0;
        sel_hi    = 1'b0;
        sel_lo    = 1'b0;
        err_total = 0;
        tests_run = 0;
        pg        = 8'h00;
        idx       = 7'h00;
        void'($urandom(18));
        repeat (20) @(posedge clk);
        @(negedge clk) arst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk_vec("reset page", 23'h000000, 23'(page_sel));
        chk_bit("reset release", 1'b1, sda_oe_n);
        // Every select setting against every address, plus a foreign one
        for (int s = 0; s < 4; s++) begin
            @(negedge clk) {sel_hi, sel_lo} = 2'(s);
            repeat (4) @(negedge clk);
            for (int m = 0; m < 5; m++) begin
                bus_master.start();
                bus_master.send((m == 4) ? 8'h90 : 8'h98 + 8'(2 * m), a);
                chk_bit("address ack", m == s, a);
                bus_master.stop();
            end
        end
        chk_vec("foreign writes", 23'h000000, 23'(seen.size()));
        $display("test address match done");
        wr_txn(8'h80, 1);
        wr_txn(8'h85, 4);
        wr_txn(8'h05, 2);
        rd_txn(8'h85, 4);
        rd_txn(8'h06, 2);
        wr_txn(8'hfe, 2);
        rd_txn(8'hfe, 3);
        wr_txn(8'hfe, 3);
        wr_txn(8'h83, 2);
        rd_txn(8'h83, 2);
        tally_and_finish();
    end

    // Watchdog: the whole run needs well under one millisecond
    initial begin
        #2000000;
        err_total++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
